// *** rtl/cdsw_params.svh ***
// Purpose: constants of the diagnostic status word bank
// Assumes: 16-bit words, word index 1 to 20
// Notes: definitions only
`ifndef CDSW_PARAMS_SVH
`define CDSW_PARAMS_SVH
`define CDSW_W_PORT_ERR 5'h01
`define CDSW_W_P1_OK 5'h02
`define CDSW_W_P2_OK 5'h03
`define CDSW_W_P1_ABORT 5'h04
`define CDSW_W_P2_ABORT 5'h05
`define CDSW_W_P1_HDR_RETRY 5'h06
`define CDSW_W_P2_HDR_RETRY 5'h07
`define CDSW_W_P1_BLK_RETRY 5'h08
`define CDSW_W_P2_BLK_RETRY 5'h09
`define CDSW_W_P1_CFG 5'h0a
`define CDSW_W_P2_CFG 5'h0b
`define CDSW_W_VERSION 5'h0c
`define CDSW_W_REQ_ERR 5'h0d
`define CDSW_W_REQ_PTR 5'h0e
`define CDSW_W_LAST 5'h14
`define CDSW_TARGET_DIAG 8'h09
`define CDSW_PE_OK 8'h00
`define CDSW_PE_TIMEOUT 8'h01
`define CDSW_PE_EXT_FIRST 8'h02
`define CDSW_PE_EXT_LAST 8'h0b
`define CDSW_PE_BLK_ABORT 8'h0c
`define CDSW_PE_HDR_ABORT 8'h0d
`define CDSW_PE_POLL_ABORT 8'h0e
`define CDSW_PE_BLK_BAD 8'h14
`define CDSW_PE_NO_EOT 8'h15
`define CDSW_PE_NO_ACKNAK 8'h16
`define CDSW_PE_MENQ_FAIL 8'h17
`define CDSW_PE_PENQ_NAK 8'h18
`define CDSW_PE_PENQ_FAIL 8'h19
`define CDSW_PE_CTS 8'h1a
`define CDSW_PE_CPU_XFER 8'h1d
`define CDSW_PE_HDR_LINE 8'h1e
`define CDSW_PE_BLK_LINE 8'h1f
`define CDSW_PE_PANEL 8'h30
`define CDSW_RE_SLAVE1 16'h0005
`define CDSW_RE_SLAVE2 16'h0006
`define CDSW_RE_PROT_ADDR 16'h0009
`define CDSW_RE_PROT_TYPE 16'h000a
`define CDSW_RE_MENQ 16'h000b
`define CDSW_RE_PENQ 16'h000c
`define CDSW_RE_PANEL 16'h0030
`define CDSW_RETRY_LIMIT 2'h3
`define CDSW_ENQ_LIMIT 6'h20
`define CDSW_VERSION 16'h0001
`endif

// *** rtl/cdsw_pkg.sv ***
// Purpose: types of the diagnostic status word bank
// Assumes: two serial ports
// Notes: no constants here, see params header
package cdsw_pkg;
  typedef enum logic [3:0] {
    CDSW_EV_NONE, CDSW_EV_OK, CDSW_EV_TIMEOUT, CDSW_EV_EXT, CDSW_EV_BLK_RETRY, CDSW_EV_HDR_RETRY,
    CDSW_EV_POLL_RETRY, CDSW_EV_BLK_BAD, CDSW_EV_NO_EOT, CDSW_EV_NO_ACKNAK, CDSW_EV_MENQ_TRY,
    CDSW_EV_PENQ_NAK, CDSW_EV_PENQ_TRY, CDSW_EV_CTS, CDSW_EV_CPU_XFER, CDSW_EV_HDR_LINE
  } cdsw_ev_e;
  typedef struct packed {
    cdsw_ev_e ev;
    logic [7:0] ext_code;
    logic blk_line;
    logic panel_busy;
  } cdsw_port_ev_s;
  typedef struct packed {
    logic [7:0] code;
    logic done;
    logic ok;
    logic abort;
    logic hdr_retry;
    logic blk_retry;
    logic enq_abort;
    logic menq;
  } cdsw_outcome_s;
  typedef struct packed {
    logic [1:0] blk_try;
    logic [1:0] hdr_try;
    logic [1:0] poll_try;
    logic [5:0] menq_try;
    logic [5:0] penq_nak;
    logic [5:0] penq_try;
  } cdsw_tracker_s;
endpackage : cdsw_pkg

// *** rtl/cdsw_port_tracker.sv ***
// Purpose: per-port conversation outcome and retry tracking
// Assumes: one event per cycle from the protocol engine
// Notes: retry and enquiry attempts counted until their limit
`include "cdsw_params.svh"
module cdsw_port_tracker (
  input wire logic I_CLK, // Clock
  input wire logic I_RESET, // Sync reset
  input wire cdsw_pkg::cdsw_port_ev_s i_ev, // Port event
  output cdsw_pkg::cdsw_outcome_s o_out // Decoded outcome, combinational
);
  cdsw_pkg::cdsw_tracker_s st;
  cdsw_pkg::cdsw_tracker_s next_st;
  // Attempt counters and outcome decode
  always_comb
  begin
    next_st = st;
    o_out = '0;
    case (i_ev.ev)
      cdsw_pkg::CDSW_EV_NONE:
      begin
        next_st = st;
      end
      cdsw_pkg::CDSW_EV_OK:
      begin
        o_out.done = 1'b1;
        o_out.ok = 1'b1;
        o_out.code = `CDSW_PE_OK; // [RL9]
        next_st = '0;
      end
      cdsw_pkg::CDSW_EV_BLK_RETRY:
      begin
        o_out.blk_retry = 1'b1; // [RL5]
        next_st.blk_try = st.blk_try + 2'h1;
        if (st.blk_try == `CDSW_RETRY_LIMIT - 2'h1)
        begin
          o_out.done = 1'b1;
          o_out.abort = 1'b1;
          o_out.code = `CDSW_PE_BLK_ABORT; // [RL11]
          next_st = '0;
        end
      end
      cdsw_pkg::CDSW_EV_HDR_RETRY:
      begin
        o_out.hdr_retry = 1'b1; // [RL4]
        next_st.hdr_try = st.hdr_try + 2'h1;
        if (st.hdr_try == `CDSW_RETRY_LIMIT - 2'h1)
        begin
          o_out.done = 1'b1;
          o_out.abort = 1'b1;
          o_out.code = `CDSW_PE_HDR_ABORT; // [RL11]
          next_st = '0;
        end
      end
      cdsw_pkg::CDSW_EV_POLL_RETRY:
      begin
        next_st.poll_try = st.poll_try + 2'h1;
        if (st.poll_try == `CDSW_RETRY_LIMIT - 2'h1)
        begin
          o_out.done = 1'b1;
          o_out.abort = 1'b1;
          o_out.code = `CDSW_PE_POLL_ABORT; // [RL11]
          next_st = '0;
        end
      end
      cdsw_pkg::CDSW_EV_MENQ_TRY:
      begin
        next_st.menq_try = st.menq_try + 6'h01;
        if (st.menq_try == `CDSW_ENQ_LIMIT - 6'h01)
        begin
          o_out.done = 1'b1;
          o_out.abort = 1'b1;
          o_out.enq_abort = 1'b1;
          o_out.menq = 1'b1;
          o_out.code = `CDSW_PE_MENQ_FAIL; // [RL14]
          next_st = '0;
        end
      end
      cdsw_pkg::CDSW_EV_PENQ_NAK:
      begin
        next_st.penq_nak = st.penq_nak + 6'h01;
        if (st.penq_nak == `CDSW_ENQ_LIMIT - 6'h01)
        begin
          o_out.done = 1'b1;
          o_out.abort = 1'b1;
          o_out.enq_abort = 1'b1;
          o_out.code = `CDSW_PE_PENQ_NAK; // [RL14]
          next_st = '0;
        end
      end
      cdsw_pkg::CDSW_EV_PENQ_TRY:
      begin
        next_st.penq_try = st.penq_try + 6'h01;
        if (st.penq_try == `CDSW_ENQ_LIMIT - 6'h01)
        begin
          o_out.done = 1'b1;
          o_out.abort = 1'b1;
          o_out.enq_abort = 1'b1;
          o_out.code = `CDSW_PE_PENQ_FAIL; // [RL14]
          next_st = '0;
        end
      end
      default:
      begin
        // Immediately terminal failures
        o_out.done = 1'b1;
        o_out.abort = 1'b1;
        next_st = '0;
        case (i_ev.ev)
          cdsw_pkg::CDSW_EV_TIMEOUT: o_out.code = `CDSW_PE_TIMEOUT; // [RL9]
          cdsw_pkg::CDSW_EV_EXT: o_out.code = i_ev.ext_code; // [RL10]
          cdsw_pkg::CDSW_EV_BLK_BAD: o_out.code = i_ev.blk_line ? `CDSW_PE_BLK_LINE : `CDSW_PE_BLK_BAD; // [RL12] [RL16]
          cdsw_pkg::CDSW_EV_NO_EOT: o_out.code = `CDSW_PE_NO_EOT; // [RL13]
          cdsw_pkg::CDSW_EV_NO_ACKNAK: o_out.code = `CDSW_PE_NO_ACKNAK; // [RL13]
          cdsw_pkg::CDSW_EV_CTS: o_out.code = `CDSW_PE_CTS; // [RL15]
          cdsw_pkg::CDSW_EV_CPU_XFER: o_out.code = `CDSW_PE_CPU_XFER; // [RL16]
          cdsw_pkg::CDSW_EV_HDR_LINE: o_out.code = `CDSW_PE_HDR_LINE; // [RL16]
          default: o_out.code = `CDSW_PE_TIMEOUT;
        endcase
      end
    endcase
  end
  // State register
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      st <= '0;
    else
      st <= next_st;
  end
  chk_enq_limit: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (i_ev.ev == cdsw_pkg::CDSW_EV_MENQ_TRY && st.menq_try == 6'h1f) |-> o_out.code == 8'h17) // [RL14]
    else $error("master enquiry abort code wrong");
endmodule : cdsw_port_tracker

// *** rtl/cdsw_word_mem.sv ***
// Purpose: storage for diagnostic words 15 to 20
// Assumes: single write port, registered read
// Notes: contents are left to the engine
module cdsw_word_mem #(
  parameter int DEPTH = 6 // Words held
) (
  input wire logic I_CLK, // Clock
  input wire logic I_RESET, // Sync reset, clears all
  input wire logic i_clear, // Clear all words
  input wire logic i_we, // Write strobe
  input wire logic [2:0] i_waddr, // Write index
  input wire logic [15:0] i_wdata, // Write data
  input wire logic [2:0] i_raddr, // Read index
  output logic [15:0] o_rdata // Registered read data
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0] rd;
  } cdsw_mem_s;
  cdsw_mem_s st;
  cdsw_mem_s next_st;
  // Refuse depths the three-bit index cannot serve
  if (DEPTH < 1 || DEPTH > 8)
  begin : g_depth_check
    $error("cdsw_word_mem depth out of range");
  end
  // Write, clear and read
  always_comb
  begin
    next_st = st;
    if (i_we && 32'(i_waddr) < DEPTH)
      next_st.mem[i_waddr] = i_wdata;
    if (i_clear)
      next_st.mem = '0;
    next_st.rd = (32'(i_raddr) < DEPTH) ? st.mem[i_raddr] : 16'h0000;
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      st <= '0;
    else
      st <= next_st;
  end
  assign o_rdata = st.rd;
endmodule : cdsw_word_mem

// *** rtl/cdsw_bank.sv ***
// Purpose: diagnostic status word bank of a two-port serial module
// Assumes: engine reports one event per port per cycle, CPU requests are pulses
// Notes: read port returns one word a cycle after the read strobe
`include "cdsw_params.svh"
// Operation
// RL1 - Word 1 holds one error byte per serial port
// RL2 - Words 2 and 3 count successful conversations per port
// RL3 - Words 4 and 5 count aborted conversations per port
// RL4 - Words 6 and 7 count header retries per port
// RL5 - Words 8 and 9 count data block retries per port
// RL6 - Word 12 returns firmware version
// RL7 - Word 13 holds last failed request error code
// RL8 - Word 14 holds reference register of last failed request
// RL9 - Error byte 0 on success, 1 on link timeout
// RL10 - Codes 2 to 11 report external access faults
// RL11 - Abort after three retries: code 12 block, 13 header, 14 poll
// RL12 - Code 20 for bad block framing characters, block line errors give code 31
// RL13 - Code 21 missing EOT, 22 missing ACK or NAK
// RL14 - Enquiry abort after 32 attempts with codes 23, 24, 25
// RL15 - Code 26 when CTS stays inactive too long
// RL16 - Code 29 CPU transfer fault, 30 header and 31 block line errors
// RL17 - Code 48 when request hits port held by operator panel
// RL18 - Request error 5 or 6 when starting on a slave port
// RL19 - Memory protect request error 9 address/length, 10 memory type
// RL20 - Request enquiry abort after 32 attempts yields request error
// RL21 - External read with target type 9 reaches these words
// RL22 - Clear zeroes words 1 to 9 and 13 to 20
// RL23 - Counters step by one per event and otherwise hold
// RL24 - Error byte overwritten by latest conversation outcome
module cdsw_bank #(
  parameter logic [15:0] VERSION = `CDSW_VERSION // Firmware version, arbitrary value
) (
  input wire logic I_CLK, // Clock
  input wire logic I_RESET, // Sync reset
  input wire cdsw_pkg::cdsw_port_ev_s I_PORT1_EV, // First port engine event
  input wire cdsw_pkg::cdsw_port_ev_s I_PORT2_EV, // Second port engine event
  input wire logic I_PORT1_IS_REQ, // First port conversation is CPU request
  input wire logic I_PORT2_IS_REQ, // Second port conversation is CPU request
  input wire logic [15:0] I_PORT1_CFG, // First port configuration image
  input wire logic [15:0] I_PORT2_CFG, // Second port configuration image
  input wire logic I_PORT1_SLAVE, // First port configured slave
  input wire logic I_PORT2_SLAVE, // Second port configured slave
  input wire logic I_REQ_START, // CPU request to start conversation
  input wire logic I_REQ_PORT, // Port of start request, 1 means second
  input wire logic I_PROT_ERR_ADDR, // Protect request bad address or length
  input wire logic I_PROT_ERR_TYPE, // Protect request bad memory type
  input wire logic [15:0] I_REQ_REF, // Reference register of current request
  input wire logic I_CLEAR, // CPU clear command
  input wire logic I_EXT_WE, // Engine write to words 15 to 20
  input wire logic [4:0] I_EXT_WADDR, // Word index for engine write
  input wire logic [15:0] I_EXT_WDATA, // Engine write data
  input wire logic I_RD, // Read strobe
  input wire logic [7:0] I_RD_TYPE, // Target memory type of read
  input wire logic [4:0] I_RD_ADDR, // Word index 1 to 20
  output logic [15:0] O_RD_DATA, // Read data, registered
  output logic O_RD_VALID, // Read data valid pulse
  output logic O_RD_ERR // Bad word index or type pulse
);
  typedef struct packed {
    logic [1:0][7:0] perr;
    logic [1:0][15:0] ok_cnt;
    logic [1:0][15:0] abort_cnt;
    logic [1:0][15:0] hdr_cnt;
    logic [1:0][15:0] blk_cnt;
    logic [15:0] req_err;
    logic [15:0] req_ptr;
    logic [15:0] rd;
    logic rd_valid;
    logic rd_err;
    logic rd_mem;
  } cdsw_bank_s;
  cdsw_bank_s st;
  cdsw_bank_s next_st;
  cdsw_pkg::cdsw_outcome_s out [2];
  cdsw_pkg::cdsw_port_ev_s ev [2];
  logic [1:0] is_req;
  logic [1:0] slave;
  logic [1:0] panel;
  logic [15:0] mem_rdata;
  logic [15:0] req_code;
  logic req_fail;
  logic rd_ok;
  assign ev[0] = I_PORT1_EV;
  assign ev[1] = I_PORT2_EV;
  assign is_req = {I_PORT2_IS_REQ, I_PORT1_IS_REQ};
  assign slave = {I_PORT2_SLAVE, I_PORT1_SLAVE};
  assign panel = {I_PORT2_EV.panel_busy, I_PORT1_EV.panel_busy};
  // Word index in range for a diagnostic read
  function automatic logic word_ok(input logic [7:0] t, input logic [4:0] a);
    word_ok = (t == `CDSW_TARGET_DIAG) && (a >= 5'h01) && (a <= `CDSW_W_LAST);
  endfunction : word_ok
  // Per-port outcome trackers
  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_port
      cdsw_port_tracker u_trk (
        .I_CLK(I_CLK),
        .I_RESET(I_RESET),
        .i_ev(ev[p]),
        .o_out(out[p])
      );
    end
  endgenerate
  // Words 15 to 20
  cdsw_word_mem #(.DEPTH(6)) u_mem (
    .I_CLK(I_CLK),
    .I_RESET(I_RESET),
    .i_clear(I_CLEAR),
    .i_we(I_EXT_WE && I_EXT_WADDR > `CDSW_W_REQ_PTR && I_EXT_WADDR <= `CDSW_W_LAST), // Index wrap guard
    .i_waddr(3'(I_EXT_WADDR - 5'h0f)),
    .i_wdata(I_EXT_WDATA),
    .i_raddr(3'(I_RD_ADDR - 5'h0f)),
    .o_rdata(mem_rdata)
  );
  // Request error decode, highest priority first
  always_comb
  begin
    req_fail = 1'b1;
    req_code = 16'h0000;
    if (I_REQ_START && panel[I_REQ_PORT])
      req_code = `CDSW_RE_PANEL; // [RL17]
    else if (I_REQ_START && slave[I_REQ_PORT])
      req_code = I_REQ_PORT ? `CDSW_RE_SLAVE2 : `CDSW_RE_SLAVE1; // [RL18]
    else if (I_PROT_ERR_ADDR)
      req_code = `CDSW_RE_PROT_ADDR; // [RL19]
    else if (I_PROT_ERR_TYPE)
      req_code = `CDSW_RE_PROT_TYPE; // [RL19]
    else if (out[0].enq_abort && is_req[0])
      req_code = out[0].menq ? `CDSW_RE_MENQ : `CDSW_RE_PENQ; // [RL20]
    else if (out[1].enq_abort && is_req[1])
      req_code = out[1].menq ? `CDSW_RE_MENQ : `CDSW_RE_PENQ; // [RL20]
    else
      req_fail = 1'b0;
  end
  assign rd_ok = word_ok(I_RD_TYPE, I_RD_ADDR);
  // Bank update and read
  always_comb
  begin
    next_st = st;
    for (int p = 0; p < 2; p++)
    begin
      if (I_REQ_START && I_REQ_PORT == p[0] && panel[p])
        next_st.perr[p] = `CDSW_PE_PANEL; // [RL17]
      else if (out[p].done)
        next_st.perr[p] = out[p].code; // [RL1] [RL24]
      if (out[p].ok)
        next_st.ok_cnt[p] = st.ok_cnt[p] + 16'h0001; // [RL2] [RL23]
      if (out[p].abort)
        next_st.abort_cnt[p] = st.abort_cnt[p] + 16'h0001; // [RL3] [RL23]
      if (out[p].hdr_retry)
        next_st.hdr_cnt[p] = st.hdr_cnt[p] + 16'h0001; // [RL4]
      if (out[p].blk_retry)
        next_st.blk_cnt[p] = st.blk_cnt[p] + 16'h0001; // [RL5]
    end
    if (req_fail)
    begin
      next_st.req_err = req_code; // [RL7]
      next_st.req_ptr = I_REQ_REF; // [RL8]
    end
    // Clear spares words 10 to 12
    if (I_CLEAR)
    begin
      next_st.perr = '0; // [RL22]
      next_st.ok_cnt = '0;
      next_st.abort_cnt = '0;
      next_st.hdr_cnt = '0;
      next_st.blk_cnt = '0;
      next_st.req_err = '0;
      next_st.req_ptr = '0;
    end
    next_st.rd_valid = I_RD;
    next_st.rd_err = I_RD && !rd_ok; // [RL21]
    next_st.rd_mem = I_RD && rd_ok && I_RD_ADDR > `CDSW_W_REQ_PTR;
    next_st.rd = 16'h0000;
    if (I_RD && rd_ok)
    begin
      case (I_RD_ADDR)
        `CDSW_W_PORT_ERR: next_st.rd = {st.perr[1], st.perr[0]}; // [RL1]
        `CDSW_W_P1_OK: next_st.rd = st.ok_cnt[0];
        `CDSW_W_P2_OK: next_st.rd = st.ok_cnt[1];
        `CDSW_W_P1_ABORT: next_st.rd = st.abort_cnt[0];
        `CDSW_W_P2_ABORT: next_st.rd = st.abort_cnt[1];
        `CDSW_W_P1_HDR_RETRY: next_st.rd = st.hdr_cnt[0];
        `CDSW_W_P2_HDR_RETRY: next_st.rd = st.hdr_cnt[1];
        `CDSW_W_P1_BLK_RETRY: next_st.rd = st.blk_cnt[0];
        `CDSW_W_P2_BLK_RETRY: next_st.rd = st.blk_cnt[1];
        `CDSW_W_P1_CFG: next_st.rd = I_PORT1_CFG;
        `CDSW_W_P2_CFG: next_st.rd = I_PORT2_CFG;
        `CDSW_W_VERSION: next_st.rd = VERSION; // [RL6]
        `CDSW_W_REQ_ERR: next_st.rd = st.req_err; // [RL7]
        `CDSW_W_REQ_PTR: next_st.rd = st.req_ptr; // [RL8]
        default: next_st.rd = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      st <= '0;
    else
      st <= next_st;
  end
  // Words 15 to 20 come from the memory register
  assign O_RD_DATA = st.rd_mem ? mem_rdata : st.rd;
  assign O_RD_VALID = st.rd_valid;
  assign O_RD_ERR = st.rd_err;
  chk_success_count: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_PORT1_EV.ev == cdsw_pkg::CDSW_EV_OK && !I_CLEAR) |=> st.ok_cnt[0] == $past(st.ok_cnt[0]) + 16'h0001) // [RL2]
    else $error("port one success count did not step");
  chk_success_code: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_PORT2_EV.ev == cdsw_pkg::CDSW_EV_OK && !I_CLEAR && !I_REQ_START) |=> st.perr[1] == 8'h00) // [RL9]
    else $error("success did not write code zero");
  chk_timeout_code: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_PORT1_EV.ev == cdsw_pkg::CDSW_EV_TIMEOUT && !I_CLEAR && !I_REQ_START) |=> st.perr[0] == 8'h01) // [RL9]
    else $error("timeout did not write code one");
  chk_abort_count: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_PORT1_EV.ev == cdsw_pkg::CDSW_EV_CTS && !I_CLEAR && !I_REQ_START)
    |=> st.abort_cnt[0] == $past(st.abort_cnt[0]) + 16'h0001
    && st.perr[0] == 8'h1a) // [RL3]
    else $error("abort not counted");
  chk_slave_start: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_REQ_START && !I_REQ_PORT && I_PORT1_SLAVE && !I_PORT1_EV.panel_busy && !I_CLEAR) |=> st.req_err == 16'h0005)
    // [RL18]
    else $error("slave start error missing");
  chk_clear_words: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_CLEAR |=> st.ok_cnt == '0 && st.req_err == 16'h0000 && st.perr == '0) // [RL22]
    else $error("clear left a word set");
  chk_count_hold: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_PORT2_EV.ev == cdsw_pkg::CDSW_EV_NONE && !I_CLEAR) |=> $stable(st.hdr_cnt[1]) && $stable(st.abort_cnt[1]))
    // [RL23]
    else $error("counter moved with no event");
  chk_version_read: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_RD_TYPE == 8'h09 && I_RD_ADDR == 5'h0c) |=> O_RD_VALID && O_RD_DATA == VERSION) // [RL6]
    else $error("version read wrong");
  chk_bad_type: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_RD_TYPE != 8'h09) |=> O_RD_ERR) // [RL21]
    else $error("wrong target type not refused");
endmodule : cdsw_bank

// *** testbench/cdsw_engine_model.sv ***
// Purpose: protocol engine stand-in that feeds port events to the bank
// Assumes: called from the bench just after a falling edge
// Notes: one event per port per cycle, panel hold kept as a level
module cdsw_engine_model (
  input wire logic I_CLK, // Clock
  output cdsw_pkg::cdsw_port_ev_s o_ev1, // First port event
  output cdsw_pkg::cdsw_port_ev_s o_ev2 // Second port event
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] panel = 2'h0;
  // Idle until asked for an event
  initial
  begin
    o_ev1 = '0;
    o_ev2 = '0;
  end
  // Operator panel hold per port
  task automatic set_panel(input logic p, input logic v);
    panel[p] = v;
    o_ev1.panel_busy = panel[0];
    o_ev2.panel_busy = panel[1];
  endtask : set_panel
  // One event for one cycle, then back to idle
  task automatic send(input logic p, input cdsw_pkg::cdsw_ev_e e, input logic [7:0] x, input logic bl);
    @(negedge I_CLK);
    if (p)
      o_ev2 = '{e, x, bl, panel[1]};
    else
      o_ev1 = '{e, x, bl, panel[0]};
    @(negedge I_CLK);
    o_ev1.ev = cdsw_pkg::CDSW_EV_NONE;
    o_ev2.ev = cdsw_pkg::CDSW_EV_NONE;
  endtask : send
endmodule : cdsw_engine_model

// *** testbench/cdsw_bank_test.sv ***
// Purpose: self-checking bench of the diagnostic word bank
// Assumes: reads answered in issue order, engine model feeds events
// Notes: expected words kept in a local image
`include "cdsw_params.svh"
module cdsw_bank_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req1 = 1'b0;
  logic req2 = 1'b0;
  logic [15:0] cfg1 = 16'h0000;
  logic [15:0] cfg2 = 16'h0000;
  logic [1:0] slave = 2'h0;
  logic start = 1'b0;
  logic rport = 1'b0;
  logic perr_a = 1'b0;
  logic perr_t = 1'b0;
  logic [15:0] ref_v = 16'h0000;
  logic clr = 1'b0;
  logic we = 1'b0;
  logic [4:0] waddr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic rd_s = 1'b0;
  logic [7:0] rtype = 8'h00;
  logic [4:0] raddr = 5'h00;
  logic [15:0] rdata;
  logic rvalid;
  logic rerr;
  cdsw_pkg::cdsw_port_ev_s ev1;
  cdsw_pkg::cdsw_port_ev_s ev2;
  logic [15:0] exp_w [0:31];
  logic [16:0] notes [$];
  logic [31:0] seed = 32'h25a01b24;
  int miscompares = 0;
  int check_count = 0;
  cdsw_pkg::cdsw_ev_e ev_tab [9] = '{cdsw_pkg::CDSW_EV_TIMEOUT, cdsw_pkg::CDSW_EV_BLK_BAD, cdsw_pkg::CDSW_EV_BLK_BAD,
    cdsw_pkg::CDSW_EV_NO_EOT, cdsw_pkg::CDSW_EV_NO_ACKNAK, cdsw_pkg::CDSW_EV_CTS, cdsw_pkg::CDSW_EV_CPU_XFER,
    cdsw_pkg::CDSW_EV_HDR_LINE, cdsw_pkg::CDSW_EV_OK};
  logic [7:0] code_tab [9] = '{8'h01, 8'h14, 8'h1f, 8'h15, 8'h16, 8'h1a, 8'h1d, 8'h1e, 8'h00};
  cdsw_pkg::cdsw_ev_e enq_tab [3] = '{cdsw_pkg::CDSW_EV_MENQ_TRY, cdsw_pkg::CDSW_EV_PENQ_NAK,
    cdsw_pkg::CDSW_EV_PENQ_TRY};
  cdsw_pkg::cdsw_ev_e rty_tab [3] = '{cdsw_pkg::CDSW_EV_BLK_RETRY, cdsw_pkg::CDSW_EV_HDR_RETRY,
    cdsw_pkg::CDSW_EV_POLL_RETRY};

  cdsw_engine_model i_eng (.I_CLK(clk), .o_ev1(ev1), .o_ev2(ev2));
  cdsw_bank i_dut (.I_CLK(clk), .I_RESET(rst), .I_PORT1_EV(ev1), .I_PORT2_EV(ev2),
    .I_PORT1_IS_REQ(req1), .I_PORT2_IS_REQ(req2), .I_PORT1_CFG(cfg1), .I_PORT2_CFG(cfg2),
    .I_PORT1_SLAVE(slave[0]), .I_PORT2_SLAVE(slave[1]), .I_REQ_START(start), .I_REQ_PORT(rport),
    .I_PROT_ERR_ADDR(perr_a), .I_PROT_ERR_TYPE(perr_t), .I_REQ_REF(ref_v), .I_CLEAR(clr),
    .I_EXT_WE(we), .I_EXT_WADDR(waddr), .I_EXT_WDATA(wdata), .I_RD(rd_s), .I_RD_TYPE(rtype),
    .I_RD_ADDR(raddr), .O_RD_DATA(rdata), .O_RD_VALID(rvalid), .O_RD_ERR(rerr));

  // Clock 50 MHz
  initial
  begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Read one word, noting the expected answer first
  task automatic rd(input logic [4:0] a, input logic [7:0] t = 8'h09);
    if (t != 8'h09 || a == 5'h00 || a > 5'h14)
      notes.push_back(17'h10000);
    else
      notes.push_back({1'b0, exp_w[a]});
    @(negedge clk);
    rd_s = 1'b1;
    rtype = t;
    raddr = a;
    @(negedge clk);
    rd_s = 1'b0;
  endtask : rd

  // CPU pulses: start, bad address, bad type, clear
  task automatic rq(input logic [3:0] sel, input logic p, input logic [15:0] code);
    @(negedge clk);
    seed = lfsr(seed);
    ref_v = seed[15:0];
    {clr, perr_t, perr_a, start} = sel;
    rport = p;
    @(negedge clk);
    {clr, perr_t, perr_a, start} = 4'h0;
    if (code != 16'h0000)
    begin
      exp_w[13] = code;
      exp_w[14] = ref_v;
      rd(5'h0d);
      rd(5'h0e);
    end
  endtask : rq

  // Engine write, only the upper words take it
  task automatic wr(input logic [4:0] a);
    @(negedge clk);
    seed = lfsr(seed);
    we = 1'b1;
    waddr = a;
    wdata = seed[15:0];
    if (a > 5'h0e)
      exp_w[a] = seed[15:0];
    @(negedge clk);
    we = 1'b0;
  endtask : wr

  // Compare each answer with the oldest note
  always @(posedge clk)
  begin
    #1;
    if (rvalid === 1'b1)
    begin
      check_count++;
      if (notes.size() == 0 || {rerr, rdata} !== notes[0])
      begin
        miscompares++;
        $display("[ERR] %0t read answer %h err %b not as noted", $time, rdata, rerr);
      end
      if (notes.size() > 0)
        void'(notes.pop_front());
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin : main
    int i;
    int k;
    seed = lfsr(seed);
    cfg1 = seed[15:0];
    cfg2 = seed[31:16];
    exp_w = '{default: 16'h0000};
    exp_w[10] = cfg1;
    exp_w[11] = cfg2;
    exp_w[12] = `CDSW_VERSION;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i <= 21; i++)
      rd(i[4:0]);
    rd(5'h01, 8'h08);
    for (i = 2; i <= 11; i++)
    begin
      i_eng.send(1'b1, cdsw_pkg::CDSW_EV_EXT, i[7:0], 1'b0);
      exp_w[1][15:8] = i[7:0];
      rd(5'h01);
    end
    for (i = 0; i < 9; i++)
    begin
      i_eng.send(1'b1, ev_tab[i], 8'h02, i == 2);
      exp_w[1][15:8] = code_tab[i];
      rd(5'h01);
    end
    for (k = 0; k < 3; k++)
    begin
      i_eng.send(1'b1, cdsw_pkg::CDSW_EV_OK, 8'h02, 1'b0);
      exp_w[1][15:8] = 8'h00;
      repeat (31) i_eng.send(1'b1, enq_tab[k], 8'h02, 1'b0);
      rd(5'h01);
      i_eng.send(1'b1, enq_tab[k], 8'h02, 1'b0);
      exp_w[1][15:8] = 8'h17 + k[7:0];
      rd(5'h01);
    end
    exp_w[3] = 16'h0004;
    exp_w[5] = 16'h0015;
    rd(5'h05);
    rd(5'h03);
    for (k = 0; k < 3; k++)
    begin
      repeat (2) i_eng.send(1'b0, rty_tab[k], 8'h02, 1'b0);
      i_eng.send(1'b0, cdsw_pkg::CDSW_EV_OK, 8'h02, 1'b0);
      repeat (3) i_eng.send(1'b0, rty_tab[k], 8'h02, 1'b0);
      exp_w[2]++;
      exp_w[4]++;
      exp_w[8 - 2 * k] += (k < 2) ? 16'h0005 : 16'h0000;
      exp_w[1][7:0] = 8'h0c + k[7:0];
      for (i = 1; i <= 9; i++)
        rd(i[4:0]);
    end
    slave = 2'h1;
    rq(4'h1, 1'b0, 16'h0005);
    slave = 2'h2;
    rq(4'h1, 1'b1, 16'h0006);
    rq(4'h6, 1'b0, 16'h0009);
    rq(4'h4, 1'b0, 16'h000a);
    slave = 2'h1;
    i_eng.set_panel(1'b0, 1'b1);
    exp_w[1][7:0] = 8'h30;
    rq(4'h1, 1'b0, 16'h0030);
    rd(5'h01);
    i_eng.set_panel(1'b0, 1'b0);
    slave = 2'h0;
    req1 = 1'b1;
    seed = lfsr(seed);
    ref_v = seed[15:0];
    repeat (32) i_eng.send(1'b0, cdsw_pkg::CDSW_EV_MENQ_TRY, 8'h02, 1'b0);
    exp_w[13] = 16'h000b;
    exp_w[14] = ref_v;
    exp_w[1][7:0] = 8'h17;
    rd(5'h0d);
    rd(5'h0e);
    rd(5'h01);
    req1 = 1'b0;
    // Peer enquiry abort of a request on the second port
    req2 = 1'b1;
    seed = lfsr(seed);
    ref_v = seed[15:0];
    repeat (32) i_eng.send(1'b1, cdsw_pkg::CDSW_EV_PENQ_TRY, 8'h02, 1'b0);
    req2 = 1'b0;
    exp_w[13] = 16'h000c;
    exp_w[14] = ref_v;
    exp_w[1][15:8] = 8'h19;
    rd(5'h0d);
    rd(5'h0e);
    rd(5'h01);
    for (i = 1; i <= 20; i++)
      wr(i[4:0]);
    for (i = 15; i <= 20; i++)
      rd(i[4:0]);
    rd(5'h03);
    rq(4'h8, 1'b0, 16'h0000);
    for (i = 1; i <= 20; i++)
      if (i < 10 || i > 12)
        exp_w[i] = 16'h0000;
    for (i = 1; i <= 20; i++)
      rd(i[4:0]);
    repeat (4) @(negedge clk);
    if (notes.size() != 0)
    begin
      miscompares++;
      $display("[ERR] %0t reads left unanswered", $time);
    end
    tally_and_finish();
  end

  // Cut a hang short
  initial
  begin
    #100us;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : cdsw_bank_test
